// File: core/serial_ext_pkg.sv
package serial_ext_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [1:0] STATUS_TWO_IDX = 2'h0;
   localparam logic [1:0] CONTROL_THREE_IDX = 2'h1;
   localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
   localparam logic [7:0] CONTROL_THREE_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Status register two fields
   // ----------------------------------------------------------------
   localparam int LIN_BREAK_FLAG_BIT = 7;
   localparam int RX_EDGE_FLAG_BIT = 6;
   localparam int RX_INVERT_BIT = 4;
   localparam int WAKE_IDLE_SEL_BIT = 3;
   localparam int LONG_BREAK_BIT = 2;
   localparam int LIN_BREAK_EN_BIT = 1;
   localparam int RX_ACTIVE_BIT = 0;

   // ----------------------------------------------------------------
   // Control register three fields
   // ----------------------------------------------------------------
   localparam int RX_NINTH_BIT = 7;
   localparam int TX_NINTH_BIT = 6;
   localparam int SINGLE_WIRE_DIR_BIT = 5;
   localparam int TX_INVERT_BIT = 4;
   localparam int OVERRUN_IRQ_BIT = 3;
   localparam int NOISE_IRQ_BIT = 2;
   localparam int FRAMING_IRQ_BIT = 1;
   localparam int PARITY_IRQ_BIT = 0;

   // ----------------------------------------------------------------
   // Break lengths in bit times, eight-bit mode
   // ----------------------------------------------------------------
   localparam logic [3:0] TX_BREAK_SHORT = 4'ha;
   localparam logic [3:0] TX_BREAK_LONG = 4'hd;
   localparam logic [3:0] RX_BREAK_SHORT = 4'ha;
   localparam logic [3:0] RX_BREAK_LIN = 4'hb;

endpackage

// File: core/serial_status_ext.sv
`timescale 1ns/10ps

// How it works
// - LIN break sets flag bit 7; write-one clears
// - Active receive edge sets bit 6; write-one clears
// - Receive invert flips receive input everywhere
// - In standby, bit 3 gates idle flag
// - Long-break bit selects 10/13 transmit break, 11/14 in nine-bit mode
// - LIN enable raises detect threshold to 11, or 12 in nine-bit mode
// - LIN enable blocks framing and receive-full flags
// - Receiver active set on start, cleared idle
// - Ninth received bit shown in control bit 7
// - Ninth transmit bit joins byte into shifter
// - Bit 5 sets transmit pin direction single-wire
// - Transmit invert flips transmit pin output
// - Overrun flag raises request when enabled
// - Noise flag raises request when enabled
// - Framing flag raises request when enabled
// - Parity flag raises request when enabled
// - Frame: low start, data lsb first, stop
module serial_status_ext
   import serial_ext_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_pin_i,
   input wire logic tx_pin_i,
   output logic tx_pin_o,
   output logic tx_pin_oe_o,
   input wire logic tx_serial_i,
   input wire logic rx_bit_tick_i,
   input wire logic nine_bit_mode_i,
   input wire logic loop_select_i,
   input wire logic rx_source_sel_i,
   input wire logic rx_standby_i,
   input wire logic rx_start_i,
   input wire logic rx_idle_i,
   input wire logic rx_char_done_i,
   input wire logic rx_stop_error_i,
   input wire logic rx_ninth_i,
   input wire logic tx_load_i,
   input wire logic [7:0] tx_data_i,
   input wire logic overrun_flag_i,
   input wire logic noise_flag_i,
   input wire logic framing_flag_i,
   input wire logic parity_flag_i,
   output logic rx_line_o,
   output logic rx_break_o,
   output logic idle_set_o,
   output logic rx_full_set_o,
   output logic framing_set_o,
   output logic [3:0] tx_break_len_o,
   output logic [8:0] tx_shift_word_o,
   output logic err_irq_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [3:0] frame_len(input logic [3:0] base,
                                            input logic nine);
      frame_len = base + {3'h0, nine};
   endfunction

   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   logic [7:0] status_two_reg;
   logic [7:0] status_two_next;
   logic [7:0] control_three_reg;
   logic [7:0] control_three_next;
   logic [2:0] rx_sync_reg;
   logic [2:0] txp_sync_reg;
   logic rx_filt_reg;
   logic txp_filt_reg;
   logic line_reg;
   logic [3:0] low_cnt_reg;
   logic low_cnt_max;
   logic break_seen_reg;
   logic ack_reg;
   logic [31:0] dat_reg;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Writes land at the edge that takes the request; the acknowledge
   // follows one cycle later and blocks a second take of the same strobe.
   // Unmapped addresses are still acknowledged and read as zero.
   wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire adr_hi_zero = (wb_adr_i[3] == 1'b0);
   wire sel_status = adr_hi_zero & (wb_adr_i[2] == STATUS_TWO_IDX[0]);
   wire sel_control = adr_hi_zero & (wb_adr_i[2] == CONTROL_THREE_IDX[0]);
   wire wr_lane = bus_req & wb_we_i & wb_sel_i[0];
   wire wr_status = wr_lane & sel_status;
   wire wr_control = wr_lane & sel_control;
   wire [7:0] wdat = wb_dat_i[7:0];
   wire [31:0] rd_data = sel_status ? {24'h0, status_two_reg} :
                         sel_control ? {24'h0, control_three_reg} :
                         32'h0;

   // ----------------------------------------------------------------
   // Receive source and break detection
   // ----------------------------------------------------------------
   wire rx_invert = status_two_reg[RX_INVERT_BIT];
   wire lin_en = status_two_reg[LIN_BREAK_EN_BIT];
   // Single-wire mode reads the transmit pin back as the receive line.
   wire single_wire = loop_select_i & rx_source_sel_i;
   wire raw_line = single_wire ? txp_filt_reg :
                   loop_select_i ? tx_serial_i : rx_filt_reg;
   wire line_now = raw_line ^ rx_invert;
   // The edge is taken on the line before inversion, so flipping the
   // inversion bit alone never counts as an active edge.
   wire pin_moved = line_reg ^ raw_line;
   wire active_edge = pin_moved & ~line_now;
   // Nine-bit mode adds one bit time to every break length.
   wire [3:0] rx_threshold = frame_len(lin_en ? RX_BREAK_LIN :
                                       RX_BREAK_SHORT,
                                       nine_bit_mode_i);
   wire break_hit = ~line_now & ~break_seen_reg &
                    (low_cnt_reg >= rx_threshold);
   wire [3:0] tx_len = frame_len(status_two_reg[LONG_BREAK_BIT] ?
                                 TX_BREAK_LONG : TX_BREAK_SHORT,
                                 nine_bit_mode_i);
   // In receive standby the idle flag is gated by the wake select bit.
   wire idle_allowed = ~rx_standby_i |
                       status_two_reg[WAKE_IDLE_SEL_BIT];
   wire [3:0] err_en = control_three_reg[OVERRUN_IRQ_BIT:PARITY_IRQ_BIT];
   // Flag order matches the enable bits in control register three.
   wire [3:0] err_flags = {overrun_flag_i, noise_flag_i,
                           framing_flag_i, parity_flag_i};
   wire tx_level = tx_serial_i ^ control_three_reg[TX_INVERT_BIT];
   // Outside single-wire mode the transmit pin is always driven.
   wire tx_drive = ~single_wire | control_three_reg[SINGLE_WIRE_DIR_BIT];
   // While LIN break detection is on, no character is handed over.
   wire rx_full_ok = rx_char_done_i & ~lin_en;

   assign low_cnt_max = (low_cnt_reg == 4'hf);

   // ----------------------------------------------------------------
   // Status register two next value
   // ----------------------------------------------------------------
   // Hardware sets come after the software clears, so an event in the
   // clearing cycle is not lost. A start wins over an idle in one cycle.
   always_comb
   begin
      status_two_next = status_two_reg;
      if (wr_status)
      begin
         status_two_next[RX_INVERT_BIT] = wdat[RX_INVERT_BIT];
         status_two_next[WAKE_IDLE_SEL_BIT] = wdat[WAKE_IDLE_SEL_BIT];
         status_two_next[LONG_BREAK_BIT] = wdat[LONG_BREAK_BIT];
         status_two_next[LIN_BREAK_EN_BIT] = wdat[LIN_BREAK_EN_BIT];
         if (wdat[LIN_BREAK_FLAG_BIT])
         begin
            status_two_next[LIN_BREAK_FLAG_BIT] = 1'b0;
         end
         if (wdat[RX_EDGE_FLAG_BIT])
         begin
            status_two_next[RX_EDGE_FLAG_BIT] = 1'b0;
         end
      end
      if (break_hit & lin_en)
      begin
         status_two_next[LIN_BREAK_FLAG_BIT] = 1'b1;
      end
      if (active_edge)
      begin
         status_two_next[RX_EDGE_FLAG_BIT] = 1'b1;
      end
      if (rx_idle_i)
      begin
         status_two_next[RX_ACTIVE_BIT] = 1'b0;
      end
      if (rx_start_i)
      begin
         status_two_next[RX_ACTIVE_BIT] = 1'b1;
      end
      // Bit 5 is reserved and always reads zero.
      status_two_next[5] = 1'b0;
   end

   // ----------------------------------------------------------------
   // Control register three next value
   // ----------------------------------------------------------------
   always_comb
   begin
      control_three_next = control_three_reg;
      if (wr_control)
      begin
         control_three_next[TX_NINTH_BIT:PARITY_IRQ_BIT] =
            wdat[TX_NINTH_BIT:PARITY_IRQ_BIT];
      end
      // The ninth bit only follows a character that is handed over, so a
      // blocked character leaves the previous value in place.
      if (rx_full_ok & nine_bit_mode_i)
      begin
         control_three_next[RX_NINTH_BIT] = rx_ninth_i;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Each pin passes three flip-flops; the filtered level only moves
   // once the last two agree, which rejects single-cycle glitches.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_sync_reg <= 3'h7;
         txp_sync_reg <= 3'h7;
         rx_filt_reg <= 1'b1;
         txp_filt_reg <= 1'b1;
      end
      else
      begin
         rx_sync_reg <= {rx_sync_reg[1:0], rx_pin_i};
         txp_sync_reg <= {txp_sync_reg[1:0], tx_pin_i};
         if (rx_sync_reg[1] == rx_sync_reg[2])
         begin
            rx_filt_reg <= rx_sync_reg[2];
         end
         if (txp_sync_reg[1] == txp_sync_reg[2])
         begin
            txp_filt_reg <= txp_sync_reg[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Low-run counter for break detection
   // ----------------------------------------------------------------
   // The count saturates, so a line stuck low cannot wrap into a second
   // break; break_seen_reg allows one report per low run.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         line_reg <= 1'b1;
         low_cnt_reg <= 4'h0;
         break_seen_reg <= 1'b0;
      end
      else
      begin
         line_reg <= raw_line;
         if (line_now)
         begin
            low_cnt_reg <= 4'h0;
            break_seen_reg <= 1'b0;
         end
         else
         begin
            if (rx_bit_tick_i & ~low_cnt_max)
            begin
               low_cnt_reg <= low_cnt_reg + 4'h1;
            end
            if (break_hit)
            begin
               break_seen_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers and the answer to the bus
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         status_two_reg <= STATUS_TWO_RESET;
         control_three_reg <= CONTROL_THREE_RESET;
         ack_reg <= 1'b0;
         dat_reg <= 32'h0;
      end
      else
      begin
         status_two_reg <= status_two_next;
         control_three_reg <= control_three_next;
         ack_reg <= bus_req;
         if (bus_req & ~wb_we_i)
         begin
            dat_reg <= rd_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs toward the pins and the rest of the port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_pin_o <= 1'b1;
         tx_pin_oe_o <= 1'b1;
         rx_line_o <= 1'b1;
         rx_break_o <= 1'b0;
         idle_set_o <= 1'b0;
         rx_full_set_o <= 1'b0;
         framing_set_o <= 1'b0;
         tx_break_len_o <= TX_BREAK_SHORT;
         tx_shift_word_o <= 9'h1ff;
         err_irq_o <= 1'b0;
      end
      else
      begin
         tx_pin_o <= tx_level;
         tx_pin_oe_o <= tx_drive;
         rx_line_o <= line_now;
         rx_break_o <= break_hit;
         idle_set_o <= rx_idle_i & idle_allowed;
         rx_full_set_o <= rx_full_ok;
         framing_set_o <= rx_full_ok & rx_stop_error_i;
         tx_break_len_o <= tx_len;
         // The held ninth bit joins the byte at the moment of loading.
         if (tx_load_i)
         begin
            tx_shift_word_o <= {control_three_reg[TX_NINTH_BIT],
                                tx_data_i};
         end
         // The request stays up as long as any enabled error flag is set.
         err_irq_o <= |(err_flags & err_en);
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

endmodule

// File: verif/serial_status_ext_props.sv
`timescale 1ns/10ps

module serial_status_ext_props
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic loop_select_i,
   input wire logic rx_source_sel_i,
   input wire logic tx_pin_oe_o,
   input wire logic tx_load_i,
   input wire logic [7:0] tx_data_i,
   input wire logic [8:0] tx_shift_word_o,
   input wire logic rx_char_done_i,
   input wire logic rx_stop_error_i,
   input wire logic rx_full_set_o,
   input wire logic framing_set_o,
   input wire logic rx_idle_i,
   input wire logic idle_set_o,
   input wire logic overrun_flag_i,
   input wire logic noise_flag_i,
   input wire logic framing_flag_i,
   input wire logic parity_flag_i,
   input wire logic err_irq_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   ack_turn_a:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered");
   ack_pulse_a:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   pin_drive_a:
      assert property (!(loop_select_i && rx_source_sel_i) |=> tx_pin_oe_o)
      else $error("transmit pin not driven");
   word_load_a:
      assert property (tx_load_i |=> tx_shift_word_o[7:0] == $past(tx_data_i))
      else $error("shift word not loaded");
   word_hold_a:
      assert property (!tx_load_i |=> $stable(tx_shift_word_o))
      else $error("shift word changed");
   full_gate_a:
      assert property (rx_full_set_o |-> $past(rx_char_done_i))
      else $error("full set without character");
   frame_gate_a:
      assert property (framing_set_o |-> rx_full_set_o && $past(rx_stop_error_i))
      else $error("framing set without cause");
   idle_gate_a:
      assert property (idle_set_o |-> $past(rx_idle_i))
      else $error("idle set without idle");
   irq_clear_a:
      assert property (!(overrun_flag_i || noise_flag_i || framing_flag_i
         || parity_flag_i) |=> !err_irq_o)
      else $error("request without flag");

   cover property (framing_set_o);
   cover property (err_irq_o);
   cover property (tx_load_i);
endmodule

bind serial_status_ext serial_status_ext_props i_props (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .loop_select_i, .rx_source_sel_i,
   .tx_pin_oe_o, .tx_load_i, .tx_data_i, .tx_shift_word_o, .rx_char_done_i,
   .rx_stop_error_i, .rx_full_set_o, .framing_set_o, .rx_idle_i, .idle_set_o,
   .overrun_flag_i, .noise_flag_i, .framing_flag_i, .parity_flag_i,
   .err_irq_o);

// File: verif/serial_node_model.sv
`timescale 1ns/10ps

module serial_node_model
(
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [4:0] bits_i,
   output logic line_o,
   output logic tick_o
);
   logic [7:0] left_reg = 8'h00;
   logic [2:0] div_reg = 3'h0;

   // The line idles high and stays low for whole bit times only.
   assign line_o = (left_reg == 8'h00);
   assign tick_o = (div_reg == 3'h7);

   always @(posedge clk_i)
   begin
      div_reg <= div_reg + 3'h1;
      if (go_i)
      begin
         // Restarting the divider keeps the ticks at a fixed phase to the
         // low run, so a run of n bits always holds n whole ticks.
         left_reg <= {bits_i, 3'h0};
         div_reg <= 3'h0;
      end
      else if (left_reg != 8'h00)
         left_reg <= left_reg - 8'h01;
   end
endmodule

// File: verif/tb.sv
`timescale 1ns/10ps

module tb;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_pin_i;
   logic [3:0] wb_adr_i, wb_sel_i, tx_break_len_o;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic tx_pin_i, tx_pin_o, tx_pin_oe_o, tx_serial_i, rx_bit_tick_i;
   logic nine_bit_mode_i, loop_select_i, rx_source_sel_i, rx_standby_i;
   logic rx_start_i, rx_idle_i, rx_char_done_i, rx_stop_error_i;
   logic rx_ninth_i, tx_load_i, overrun_flag_i, noise_flag_i;
   logic framing_flag_i, parity_flag_i, rx_line_o, rx_break_o, idle_set_o;
   logic rx_full_set_o, framing_set_o, err_irq_o, go, brk_seen;
   logic [7:0] tx_data_i, q, v;
   logic [8:0] tx_shift_word_o;
   logic [4:0] bits;
   int err_count, checked, cycles, seed, i;

   assign tx_pin_i = tx_pin_oe_o ? tx_pin_o : 1'b1;

   serial_status_ext i_serial_status_ext (.clk_i, .rst_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .rx_pin_i, .tx_pin_i, .tx_pin_o, .tx_pin_oe_o, .tx_serial_i,
      .rx_bit_tick_i, .nine_bit_mode_i, .loop_select_i, .rx_source_sel_i,
      .rx_standby_i, .rx_start_i, .rx_idle_i, .rx_char_done_i,
      .rx_stop_error_i, .rx_ninth_i, .tx_load_i, .tx_data_i, .overrun_flag_i,
      .noise_flag_i, .framing_flag_i, .parity_flag_i, .rx_line_o, .rx_break_o,
      .idle_set_o, .rx_full_set_o, .framing_set_o, .tx_break_len_o,
      .tx_shift_word_o, .err_irq_o);
   serial_node_model i_serial_node_model (.clk_i, .go_i(go), .bits_i(bits),
      .line_o(rx_pin_i), .tick_o(rx_bit_tick_i));

   initial
   begin
      clk_i = 0;
      forever #12.5 clk_i = ~clk_i;
   end

   function logic [8:0] brk_len(input int k);
      return (k[1] ? 9'hd : 9'ha) + 9'(k[0]);
   endfunction

   task stop_test;
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input string n, input logic [8:0] s, input logic [8:0] e);
      checked++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task bus(input logic [3:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      q = wb_dat_o[7:0];
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask

   task rd(input logic [3:0] a, input logic [7:0] e, input string n);
      bus(a, 0, 8'h00);
      chk(n, {1'b0, q}, {1'b0, e});
   endtask

   task settle;
      repeat (8) @(posedge clk_i);
   endtask

   // Pulses {start, idle, done, stop error} for one cycle.
   task ev(input logic [3:0] p);
      @(posedge clk_i);
      {rx_start_i, rx_idle_i, rx_char_done_i, rx_stop_error_i} <= p;
      @(posedge clk_i);
      {rx_start_i, rx_idle_i, rx_char_done_i, rx_stop_error_i} <= 4'h0;
      @(posedge clk_i);
   endtask

   task send(input logic [4:0] n);
      @(posedge clk_i);
      bits <= n;
      go <= 1;
      @(posedge clk_i);
      go <= 0;
      repeat (n * 8 + 12) @(posedge clk_i);
   endtask

   always @(posedge clk_i)
      if (go)
         brk_seen <= 0;
      else if (rx_break_o)
         brk_seen <= 1;

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         stop_test;
      end
   end

   initial
   begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, nine_bit_mode_i,
         loop_select_i, rx_source_sel_i, rx_standby_i, rx_start_i, rx_idle_i,
         rx_char_done_i, rx_stop_error_i, rx_ninth_i, tx_load_i, tx_data_i,
         overrun_flag_i, noise_flag_i, framing_flag_i, parity_flag_i, go,
         bits} = '0;
      {tx_serial_i, rst_i, wb_sel_i} = 6'h3f;
      seed = 30345;
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      rd(4'h0, 8'h00, "s2 reset");
      rd(4'h4, 8'h00, "c3 reset");
      bus(4'h0, 1, 8'hef);
      rd(4'h0, 8'h0e, "s2 access");
      bus(4'h8, 1, 8'hff);
      rd(4'h8, 8'h00, "unmapped");
      v = $random(seed);
      bus(4'h4, 1, v);
      rd(4'h4, v & 8'h7f, "c3 access");
      wb_sel_i <= 4'h0;
      bus(4'h4, 1, ~v);
      wb_sel_i <= 4'hf;
      rd(4'h4, v & 8'h7f, "sel off");
      $display("regs done");
      for (i = 0; i < 4; i++)
      begin
         nine_bit_mode_i <= i[0];
         bus(4'h0, 1, {5'h0, i[1], 2'h0});
         settle;
         chk("break len", 9'(tx_break_len_o), brk_len(i));
      end
      nine_bit_mode_i <= 0;
      bus(4'h4, 1, 8'h50);
      v = $random(seed);
      tx_data_i <= v;
      tx_load_i <= 1;
      tx_serial_i <= 0;
      @(posedge clk_i);
      tx_load_i <= 0;
      settle;
      chk("shift word", tx_shift_word_o, {1'b1, v});
      chk("tx pin", 9'(tx_pin_o), 9'h1);
      tx_serial_i <= 1;
      {loop_select_i, rx_source_sel_i} <= 2'h3;
      bus(4'h4, 1, 8'h00);
      settle;
      chk("pin input", 9'(tx_pin_oe_o), 9'h0);
      bus(4'h4, 1, 8'h20);
      settle;
      chk("pin output", 9'(tx_pin_oe_o), 9'h1);
      {loop_select_i, rx_source_sel_i} <= 2'h0;
      $display("tx done");
      for (i = 0; i < 4; i++)
      begin
         {overrun_flag_i, noise_flag_i, framing_flag_i, parity_flag_i}
            <= 4'h1 << i;
         bus(4'h4, 1, 8'h0f ^ (8'h1 << i));
         settle;
         chk("irq off", 9'(err_irq_o), 9'h0);
         bus(4'h4, 1, 8'h1 << i);
         settle;
         chk("irq on", 9'(err_irq_o), 9'h1);
      end
      {overrun_flag_i, noise_flag_i, framing_flag_i, parity_flag_i} <= 4'h0;
      bus(4'h4, 1, 8'h00);
      bus(4'h0, 1, 8'h10);
      settle;
      chk("rx invert", 9'(rx_line_o), 9'h0);
      rd(4'h0, 8'h10, "invert no edge");
      bus(4'h0, 1, 8'hc0);
      settle;
      send(10);
      chk("break 10", 9'(brk_seen), 9'h1);
      rd(4'h0, 8'h40, "edge no lin");
      bus(4'h0, 1, 8'hc2);
      send(10);
      chk("lin 10", 9'(brk_seen), 9'h0);
      rd(4'h0, 8'h42, "lin 10 bits");
      bus(4'h0, 1, 8'hc2);
      send(11);
      rd(4'h0, 8'hc2, "lin 11 bits");
      bus(4'h0, 1, 8'h82);
      rd(4'h0, 8'h42, "lin clear");
      nine_bit_mode_i <= 1;
      bus(4'h0, 1, 8'hc2);
      send(11);
      rd(4'h0, 8'h42, "lin nine 11");
      bus(4'h0, 1, 8'hc2);
      send(12);
      rd(4'h0, 8'hc2, "lin nine 12");
      bus(4'h0, 1, 8'h82);
      $display("break done");
      ev(4'h3);
      chk("full lin", {7'h0, rx_full_set_o, framing_set_o}, 9'h0);
      bus(4'h0, 1, 8'h40);
      nine_bit_mode_i <= 1;
      rx_ninth_i <= 1;
      ev(4'h3);
      chk("full", {7'h0, rx_full_set_o, framing_set_o}, 9'h3);
      rd(4'h4, 8'h80, "ninth rx");
      ev(4'h8);
      rd(4'h0, 8'h01, "active");
      ev(4'h4);
      rd(4'h0, 8'h00, "idle");
      rx_standby_i <= 1;
      ev(4'h4);
      chk("standby off", 9'(idle_set_o), 9'h0);
      bus(4'h0, 1, 8'h08);
      ev(4'h4);
      chk("standby on", 9'(idle_set_o), 9'h1);
      $display("events done");
      stop_test;
   end
endmodule
